// [design/aeo_defines.vh]
// Constants shared by the angle encoder output logic
`ifndef AEO_DEFINES_VH
`define AEO_DEFINES_VH

// Clock and timing figures
`define AEO_CLK_MHZ              125
`define AEO_LATCH_SETUP_NS       500
`define AEO_READ_GAP_US          20
`define AEO_FRAME_TIMEOUT_US     20
`define AEO_LOW_HOLD_LIMIT_US    10
`define AEO_LATCH_SETUP_CYC      ((`AEO_LATCH_SETUP_NS * `AEO_CLK_MHZ) / 1000)
`define AEO_FRAME_TIMEOUT_CYC    (`AEO_FRAME_TIMEOUT_US * `AEO_CLK_MHZ)
`define AEO_LOW_HOLD_LIMIT_CYC   (`AEO_LOW_HOLD_LIMIT_US * `AEO_CLK_MHZ)

// Angle and output widths
`define AEO_ANGLE_W              16
`define AEO_PWM_W                10
`define AEO_PWM_LAST_UNIT        11'h400
`define AEO_PWM_UNIT_CYC         16'h007d

// Wishbone register offsets (byte addresses)
`define AEO_REG_CTRL             4'h0
`define AEO_REG_ANGLE            4'h4
`define AEO_REG_STATUS           4'h8
`define AEO_REG_CONF             4'hc

// Control register fields
`define AEO_CTRL_QUAD_EN         0
`define AEO_CTRL_COMM_EN         1
`define AEO_CTRL_PWM_EN          2

// Configuration register fields
`define AEO_CONF_CPR_LSB         0
`define AEO_CONF_CPR_MSB         3
`define AEO_CONF_IDXW_LSB        4
`define AEO_CONF_IDXW_MSB        5
`define AEO_CONF_POLE_LSB        6
`define AEO_CONF_POLE_MSB        7

// Reset values
`define AEO_CTRL_RST             3'h7
`define AEO_CONF_RST             8'h17

// Serial read states
`define AEO_SS_IDLE              2'h0
`define AEO_SS_SHIFT             2'h1
`define AEO_SS_DONE              2'h2

`endif

// [design/aeo_sync2.v]
// Two-flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module aeo_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  input  wire sys_clk,
  input  wire reset,
  input  wire async_in,
  output reg  sync_out
);
  reg meta_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // aeo_sync2
`default_nettype wire

// [design/aeo_pwm.v]
// Pulse-width output of the 10-bit absolute position
`timescale 1ns/1ps
`include "aeo_defines.vh"
`default_nettype none
module aeo_pwm #(
  parameter UNIT_CYC = `AEO_PWM_UNIT_CYC
) (
  input  wire                   sys_clk,
  input  wire                   reset,
  input  wire                   enable,
  input  wire [`AEO_PWM_W-1:0]  position,
  output reg                    pwm_out
);
  reg [15:0]            unit_cnt_r;
  reg [10:0]            slot_r;
  reg [`AEO_PWM_W-1:0]  pos_r;
  wire                  unit_end;

  assign unit_end = (unit_cnt_r == UNIT_CYC - 16'h0001);

  // Period is 1025 units; high for position plus one units
  always @(posedge sys_clk) begin
    if (reset) begin
      unit_cnt_r <= 16'h0000;
      slot_r     <= 11'h000;
      pos_r      <= {`AEO_PWM_W{1'b0}};
      pwm_out    <= 1'b0;
    end else begin
      unit_cnt_r <= unit_end ? 16'h0000 : unit_cnt_r + 16'h0001;
      if (unit_end) begin
        if (slot_r == `AEO_PWM_LAST_UNIT) begin
          slot_r <= 11'h000;
          pos_r  <= position;
        end else begin
          slot_r <= slot_r + 11'h001;
        end
      end
      pwm_out <= enable && (slot_r <= {1'b0, pos_r});
    end
  end
endmodule // aeo_pwm
`default_nettype wire

// [design/aeo_top.v]
// Angle encoder output logic: serial read, quadrature, commutation, pulse width
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "aeo_defines.vh"
`default_nettype none
module aeo_top #(
  parameter FRAME_TIMEOUT_CYC   = `AEO_FRAME_TIMEOUT_CYC,
  parameter LOW_HOLD_LIMIT_CYC  = `AEO_LOW_HOLD_LIMIT_CYC,
  parameter PWM_UNIT_CYC        = `AEO_PWM_UNIT_CYC
) (
  input  wire                     sys_clk,
  input  wire                     reset,
  // Wishbone slave
  input  wire                     wb_cyc_i,
  input  wire                     wb_stb_i,
  input  wire                     wb_we_i,
  input  wire [3:0]               wb_adr_i,
  input  wire [3:0]               wb_sel_i,
  input  wire [31:0]              wb_dat_i,
  output reg  [31:0]              wb_dat_o,
  output reg                      wb_ack_o,
  // Angle from the measurement front end
  input  wire [`AEO_ANGLE_W-1:0]  angle_in,
  input  wire                     angle_valid,
  // Serial read link
  input  wire                     select_n,
  input  wire                     ser_clk,
  output reg                      ser_data_o,
  output reg                      ser_data_oe_n,
  // Quadrature and index
  output reg                      quad_a,
  output reg                      quad_b,
  output reg                      quad_index,
  // Commutation
  output reg  [2:0]               commutation_outputs,
  // Pulse width
  output wire                     pwm_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Local constants
  // Serial read states
  localparam [1:0]  SS_IDLE       = `AEO_SS_IDLE;
  localparam [1:0]  SS_SHIFT      = `AEO_SS_SHIFT;
  localparam [1:0]  SS_DONE       = `AEO_SS_DONE;
  // Counts cut on purpose to the 16-bit counters that load or compare them
  localparam [31:0] TIMEOUT_CYC_W = FRAME_TIMEOUT_CYC;
  localparam [31:0] LOW_LAST_W    = LOW_HOLD_LIMIT_CYC - 1;
  localparam [15:0] TIMEOUT_LOAD  = TIMEOUT_CYC_W[15:0];
  localparam [15:0] LOW_HOLD_LAST = LOW_LAST_W[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [2:0]               ctrl_r;
  reg [7:0]               conf_r;
  reg [`AEO_ANGLE_W-1:0]  angle_r;
  reg                     frame_end_seen_r;
  reg                     low_limit_seen_r;
  wire                    wb_req;
  wire                    quad_en;
  wire                    comm_en;
  wire                    pwm_en;
  wire [3:0]              cpr_sel;
  wire [1:0]              idxw_sel;
  wire [1:0]              pole_sel;
  wire                    frame_end_evt;
  wire                    low_limit_evt;

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign quad_en  = ctrl_r[`AEO_CTRL_QUAD_EN];
  assign comm_en  = ctrl_r[`AEO_CTRL_COMM_EN];
  assign pwm_en   = ctrl_r[`AEO_CTRL_PWM_EN];
  assign cpr_sel  = conf_r[`AEO_CONF_CPR_MSB:`AEO_CONF_CPR_LSB];
  assign idxw_sel = conf_r[`AEO_CONF_IDXW_MSB:`AEO_CONF_IDXW_LSB];
  assign pole_sel = conf_r[`AEO_CONF_POLE_MSB:`AEO_CONF_POLE_LSB];

  // Newest angle kept on each cycle with angle_valid high; held otherwise
  always @(posedge sys_clk) begin
    if (reset) begin
      angle_r <= {`AEO_ANGLE_W{1'b0}};
    end else if (angle_valid) begin
      angle_r <= angle_in;
    end
  end

  // Single-cycle ack; status bits set wins over write-one clear
  always @(posedge sys_clk) begin
    if (reset) begin
      ctrl_r           <= `AEO_CTRL_RST;
      conf_r           <= `AEO_CONF_RST;
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h00000000;
      frame_end_seen_r <= 1'b0;
      low_limit_seen_r <= 1'b0;
    end else begin
      // Unmapped offsets read zero; writes with byte lane 0 off are dropped
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `AEO_REG_CTRL) begin
          ctrl_r <= wb_dat_i[2:0];
        end
        if (wb_adr_i == `AEO_REG_CONF) begin
          conf_r <= wb_dat_i[7:0];
        end
      end
      if (frame_end_evt) begin
        frame_end_seen_r <= 1'b1;
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `AEO_REG_STATUS && wb_dat_i[0]) begin
        frame_end_seen_r <= 1'b0;
      end
      if (low_limit_evt) begin
        low_limit_seen_r <= 1'b1;
      end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `AEO_REG_STATUS && wb_dat_i[1]) begin
        low_limit_seen_r <= 1'b0;
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `AEO_REG_CTRL:   wb_dat_o <= {29'h00000000, ctrl_r};
          `AEO_REG_ANGLE:  wb_dat_o <= {16'h0000, angle_r};
          `AEO_REG_STATUS: wb_dat_o <= {30'h00000000, low_limit_seen_r, frame_end_seen_r};
          `AEO_REG_CONF:   wb_dat_o <= {24'h000000, conf_r};
          default:         wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial read link
  wire sel_n_s;
  wire sclk_s;
  reg  sclk_d_r;
  reg  sel_n_d_r;
  reg  [1:0]               ss_state_r;
  reg  [`AEO_ANGLE_W-1:0]  shift_r;
  reg  [4:0]               bit_cnt_r;
  reg  [15:0]              timeout_r;
  reg  [15:0]              low_cnt_r;
  wire sclk_rise;
  wire sclk_fall;
  wire sel_fall;

  aeo_sync2 #(.RESET_VAL(1'b1)) u_sync_sel (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (select_n),
    .sync_out (sel_n_s)
  );

  aeo_sync2 #(.RESET_VAL(1'b1)) u_sync_clk (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (ser_clk),
    .sync_out (sclk_s)
  );

  assign sclk_rise = sclk_s && !sclk_d_r;
  assign sclk_fall = !sclk_s && sclk_d_r;
  assign sel_fall  = !sel_n_s && sel_n_d_r;
  // Link edges arrive three cycles late through the synchronisers, which
  // leaves most of a half period of a 1 MHz link clock before the master samples
  assign frame_end_evt = (ss_state_r == SS_SHIFT) && (timeout_r == 16'h0001);
  assign low_limit_evt = !ser_data_oe_n && !ser_data_o && (low_cnt_r == LOW_HOLD_LAST);

  always @(posedge sys_clk) begin
    if (reset) begin
      sclk_d_r      <= 1'b1;
      sel_n_d_r     <= 1'b1;
      ss_state_r    <= SS_IDLE;
      shift_r       <= {`AEO_ANGLE_W{1'b0}};
      bit_cnt_r     <= 5'h00;
      timeout_r     <= 16'h0000;
      low_cnt_r     <= 16'h0000;
      ser_data_o    <= 1'b1;
      ser_data_oe_n <= 1'b1;
    end else begin
      sclk_d_r  <= sclk_s;
      sel_n_d_r <= sel_n_s;
      // Low-hold watchdog releases the line
      if (!ser_data_oe_n && !ser_data_o) begin
        low_cnt_r <= low_cnt_r + 16'h0001;
      end else begin
        low_cnt_r <= 16'h0000;
      end
      case (ss_state_r)
        SS_IDLE: begin
          ser_data_oe_n <= 1'b1;
          ser_data_o    <= 1'b1;
          if (sel_fall) begin
            shift_r       <= angle_r;
            bit_cnt_r     <= 5'h00;
            timeout_r     <= TIMEOUT_LOAD;
            ser_data_oe_n <= 1'b0;
            ss_state_r    <= SS_SHIFT;
          end
        end
        SS_SHIFT: begin
          if (sel_n_s) begin
            ser_data_oe_n <= 1'b1;
            ser_data_o    <= 1'b1;
            ss_state_r    <= SS_IDLE;
          end else if (low_limit_evt) begin
            ser_data_oe_n <= 1'b1;
            ser_data_o    <= 1'b1;
            ss_state_r    <= SS_DONE;
          end else if (frame_end_evt) begin
            ss_state_r <= SS_DONE;
          end else begin
            if (timeout_r != 16'h0000) begin
              timeout_r <= timeout_r - 16'h0001;
            end
            // Only falling edges restart the quiet-time count
            if (sclk_fall) begin
              timeout_r <= TIMEOUT_LOAD;
            end
            if (sclk_rise) begin
              ser_data_o <= shift_r[`AEO_ANGLE_W-1];
              shift_r    <= {shift_r[`AEO_ANGLE_W-2:0], 1'b0};
              bit_cnt_r  <= bit_cnt_r + 5'h01;
            end
          end
        end
        SS_DONE: begin
          // Line stays released until the master deselects; a cut frame is not resumed
          ser_data_oe_n <= 1'b1;
          ser_data_o    <= 1'b1;
          if (sel_n_s) begin
            ss_state_r <= SS_IDLE;
          end
        end
        default: ss_state_r <= SS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quadrature and index
  // Counts per turn is 8 << cpr_sel, cpr_sel above 7 acting as 7; two extra fraction bits give four states per count
  reg  [11:0] quad_phase;
  reg  [11:0] idx_lim;
  reg  [11:0] pos_cnt_r;
  reg  [11:0] prev_phase_r;
  wire [11:0] quad_mask;
  wire [3:0]  cpr_clamped;

  assign cpr_clamped = (cpr_sel > 4'h7) ? 4'h7 : cpr_sel;
  assign quad_mask   = (12'h020 << cpr_clamped) - 12'h001;

  always @* begin
    quad_phase = angle_r[15:4] >> (4'h7 - cpr_clamped);
    case (idxw_sel)
      2'h0:    idx_lim = 12'h001;
      2'h1:    idx_lim = 12'h002;
      2'h2:    idx_lim = 12'h003;
      default: idx_lim = 12'h004;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      quad_a       <= 1'b0;
      quad_b       <= 1'b0;
      quad_index   <= 1'b0;
      pos_cnt_r    <= 12'h000;
      prev_phase_r <= 12'h000;
    end else begin
      prev_phase_r <= quad_phase;
      if (quad_en) begin
        quad_a     <= quad_phase[1];
        quad_b     <= quad_phase[1] ^ quad_phase[0];
        quad_index <= ((quad_phase & quad_mask) < idx_lim);
        // A step into phase zero marks a completed turn
        if ((quad_phase & quad_mask) == 12'h000 && prev_phase_r != quad_phase) begin
          pos_cnt_r <= 12'h000;
        end else if (quad_phase != prev_phase_r) begin
          pos_cnt_r <= quad_phase;
        end
      end else begin
        quad_a     <= 1'b0;
        quad_b     <= 1'b0;
        quad_index <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commutation: six Hall states per electrical turn
  reg  [15:0] elec_angle;
  reg  [2:0]  sector;
  wire [18:0] sector_prod;

  always @* begin
    elec_angle = angle_r << pole_sel;
  end
  assign sector_prod = elec_angle * 3'h6;

  always @* begin
    sector = sector_prod[18:16];
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      commutation_outputs <= 3'h0;
    end else if (comm_en) begin
      case (sector)
        3'h0:    commutation_outputs <= 3'h5;
        3'h1:    commutation_outputs <= 3'h4;
        3'h2:    commutation_outputs <= 3'h6;
        3'h3:    commutation_outputs <= 3'h2;
        3'h4:    commutation_outputs <= 3'h3;
        default: commutation_outputs <= 3'h1;
      endcase
    end else begin
      commutation_outputs <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse width
  aeo_pwm #(.UNIT_CYC(PWM_UNIT_CYC)) u_pwm (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .enable   (pwm_en),
    .position (angle_r[15:6]),
    .pwm_out  (pwm_out)
  );
endmodule // aeo_top
`default_nettype wire

// [bench/aeo_checker.sv]
// Port checks for the angle encoder outputs
`timescale 1ns/1ps
`default_nettype none
module aeo_checker #(
  parameter FRAME_TIMEOUT_CYC  = 2500,
  parameter LOW_HOLD_LIMIT_CYC = 1250
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        select_n,
  input wire logic        ser_clk,
  input wire logic        ser_data_o,
  input wire logic        ser_data_oe_n
);
  logic [15:0] idle_r;
  logic [15:0] low_r;
  logic        clk_q_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Idle time of the link clock in a frame, and time the line is driven low
  always @(posedge sys_clk) begin
    clk_q_r <= ser_clk;
    if (reset || select_n || ser_clk != clk_q_r) idle_r <= 16'h0000;
    else if (idle_r != 16'hffff) idle_r <= idle_r + 16'h0001;
    if (reset || ser_data_oe_n || ser_data_o) low_r <= 16'h0000;
    else if (low_r != 16'hffff) low_r <= low_r + 16'h0001;
  end
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_req_a: assert property (wb_req_s |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
  drive_start_a: assert property ($fell(select_n) |-> ##[1:6] !ser_data_oe_n) else $error("no drive");
  drive_off_a: assert property (select_n [*5] |-> ser_data_oe_n) else $error("driven unselected");
  frame_end_a: assert property (idle_r > FRAME_TIMEOUT_CYC + 8 |-> ser_data_oe_n) else $error("no timeout");
  low_limit_a: assert property (low_r <= LOW_HOLD_LIMIT_CYC + 4) else $error("low too long");
endmodule // aeo_checker
bind aeo_top aeo_checker #(.FRAME_TIMEOUT_CYC(FRAME_TIMEOUT_CYC), .LOW_HOLD_LIMIT_CYC(LOW_HOLD_LIMIT_CYC)) chk_u (
  .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .select_n(select_n), .ser_clk(ser_clk), .ser_data_o(ser_data_o),
  .ser_data_oe_n(ser_data_oe_n));
`default_nettype wire

// [bench/aeo_ssi_master.sv]
// Behavioural serial read master on the link
`timescale 1ns/1ps
`default_nettype none
module aeo_ssi_master (
  input  wire logic        start,
  input  wire logic [5:0]  nclk,
  input  wire logic [15:0] hold_ns,
  input  wire logic        data_in,
  output var  logic        select_n,
  output var  logic        ser_clk,
  output var  logic [31:0] rx_word,
  output var  logic        done
);
  integer i;
  initial begin
    select_n = 1'b1;
    ser_clk  = 1'b1;
    rx_word  = 32'h0;
    done     = 1'b1;
    forever begin
      @(posedge start);
      done = 1'b0;
      rx_word = 32'h0;
      #3.3 select_n = 1'b0;
      #500;
      // Clock stands high outside frames; bits taken on falling edges
      for (i = 0; i <= nclk; i = i + 1) begin
        ser_clk = 1'b0;
        if (i > 0) rx_word = {rx_word[30:0], data_in};
        #40;
        if (i < nclk) begin
          ser_clk = 1'b1;
          #40;
        end
      end
      #(hold_ns) ser_clk = 1'b1;
      #40 select_n = 1'b1;
      #20000 done = 1'b1;
    end
  end
endmodule // aeo_ssi_master
`default_nettype wire

// [bench/aeo_top_tb.sv]
// Self-checking bench of the angle encoder output logic
`timescale 1ns/1ps
`include "aeo_defines.vh"
`default_nettype none
module aeo_top_tb;
  localparam int UNIT = 2;
  logic        sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, angle_valid, start, cnt_en;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, rd, seed;
  logic [15:0] angle_in, hold_ns, a;
  logic [5:0]  nclk;
  logic [1:0]  pq;
  logic [2:0]  pc;
  wire  [31:0] wb_dat_o, rx_word;
  wire  [2:0]  commutation_outputs;
  wire         wb_ack_o, select_n, ser_clk, ser_data_o, ser_data_oe_n, quad_a, quad_b, quad_index, pwm_out, done;
  wire         ser_line = ser_data_oe_n ? 1'b1 : ser_data_o;
  integer      n_errors = 0, num_checks = 0, nq, nd, ni, nc, nh, i, k;
  aeo_top #(.FRAME_TIMEOUT_CYC(100), .LOW_HOLD_LIMIT_CYC(200), .PWM_UNIT_CYC(UNIT)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .angle_in(angle_in), .angle_valid(angle_valid), .select_n(select_n), .ser_clk(ser_clk),
    .ser_data_o(ser_data_o), .ser_data_oe_n(ser_data_oe_n), .quad_a(quad_a), .quad_b(quad_b),
    .quad_index(quad_index), .commutation_outputs(commutation_outputs), .pwm_out(pwm_out));
  aeo_ssi_master mst_u (.start(start), .nclk(nclk), .hold_ns(hold_ns), .data_in(ser_line),
    .select_n(select_n), .ser_clk(ser_clk), .rx_word(rx_word), .done(done));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Output activity inside a sweep window
  always @(posedge sys_clk) begin
    pq <= {quad_a, quad_b};
    pc <= commutation_outputs;
    if (cnt_en) begin
      if ({quad_a, quad_b} !== pq) nq <= nq + 1;
      if (quad_a !== pq[1] && quad_b !== pq[0]) nd <= nd + 1;
      if (commutation_outputs !== pc) nc <= nc + 1;
      if (commutation_outputs === 3'h0 || commutation_outputs === 3'h7) nh <= nh + 1;
      if (quad_index === 1'b1) ni <= ni + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] pwm_hi(input logic [15:0] v);
    pwm_hi = (32'(v[15:6]) + 32'd1) * UNIT;
  endfunction
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang;
    n_errors = n_errors + 1;
    $display("Error at %0t: wait limit reached", $time);
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] ad, input logic [3:0] s, input logic [31:0] d);
    integer t;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= ad;
    wb_sel_i <= s;
    wb_dat_i <= d;
    for (t = 0; t < 40; t = t + 1) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (t == 40) hang();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [3:0] ad, input logic [31:0] exp);
    wb(1'b0, ad, 4'hf, 32'h0);
    chk(rd, exp);
  endtask
  task automatic ssi(input logic [5:0] n, input logic [15:0] h);
    integer t;
    nclk <= n;
    hold_ns <= h;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (t = 0; t < 5000; t = t + 1) begin
      @(negedge sys_clk);
      if (done === 1'b1) break;
    end
    if (t == 5000) hang();
    @(posedge sys_clk);
  endtask
  // One turn in n equal steps, three cycles each, counted in a 3n-cycle window
  task automatic swp(input logic [15:0] step, input integer n);
    angle_in <= step >> 1;
    repeat (4) @(posedge sys_clk);
    nq = 0;
    nd = 0;
    nc = 0;
    nh = 0;
    ni = 0;
    cnt_en <= 1'b1;
    for (k = 1; k <= n; k = k + 1) begin
      angle_in <= 16'(k * step + (step >> 1));
      repeat (3) @(posedge sys_clk);
    end
    cnt_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic pw(input logic lvl, output integer c);
    for (c = 0; c < 5000 && pwm_out !== lvl; c = c + 1) @(negedge sys_clk);
    if (c == 5000) hang();
  endtask
  task automatic pm(input logic [15:0] v);
    integer c, hi, lo;
    angle_in <= v;
    pw(1'b0, c);
    pw(1'b1, c);
    pw(1'b0, c);
    pw(1'b1, c);
    pw(1'b0, hi);
    pw(1'b1, lo);
    chk(hi, pwm_hi(v));
    chk(hi + lo, 1025 * UNIT);
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, start, cnt_en} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
    {angle_valid, angle_in, hold_ns, nclk} = {1'b1, 16'h0, 16'h0, 6'h10};
    seed = 32'h53656ae3;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdc(`AEO_REG_CTRL, 32'h7);
    rdc(`AEO_REG_CONF, 32'h17);
    rdc(`AEO_REG_STATUS, 32'h0);
    rdc(4'h2, 32'h0);
    wb(1'b1, `AEO_REG_CONF, 4'he, 32'h0);
    rdc(`AEO_REG_CONF, 32'h17);
    seed = lfsr(seed);
    wb(1'b1, `AEO_REG_CONF, 4'h1, {24'h0, seed[7:0]});
    rdc(`AEO_REG_CONF, {24'h0, seed[7:0]});
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      a = (i == 0) ? 16'h8001 : (i == 1) ? 16'h7ffe : seed[15:0];
      angle_in <= a;
      repeat (4) @(posedge sys_clk);
      wb(1'b1, `AEO_REG_ANGLE, 4'hf, ~{16'h0, a});
      rdc(`AEO_REG_ANGLE, {16'h0, a});
      ssi(6'd16, 16'd0);
      chk(rx_word, {16'h0, a});
    end
    angle_valid <= 1'b0;
    angle_in <= ~a;
    repeat (4) @(posedge sys_clk);
    rdc(`AEO_REG_ANGLE, {16'h0, a});
    angle_valid <= 1'b1;
    angle_in <= 16'hffff;
    ssi(6'd4, 16'd1500);
    rdc(`AEO_REG_STATUS, 32'h1);
    wb(1'b1, `AEO_REG_STATUS, 4'h1, 32'h3);
    rdc(`AEO_REG_STATUS, 32'h0);
    angle_in <= 16'h8000;
    ssi(6'd26, 16'd0);
    rdc(`AEO_REG_STATUS, 32'h2);
    for (i = 0; i < 8; i = i + 1) begin
      wb(1'b1, `AEO_REG_CONF, 4'h1, {28'h1, 4'(i)});
      swp(16'(2048 >> i), 32 << i);
      chk(nq, 32 << i);
      chk(nd, 0);
      chk(ni, 6);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wb(1'b1, `AEO_REG_CONF, 4'h1, {26'h0, 2'(i), 4'h0});
      swp(16'd2048, 32);
      chk(ni, (i + 1) * 3);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wb(1'b1, `AEO_REG_CONF, 4'h1, {24'h0, 2'(i), 6'h10});
      swp(16'd256, 256);
      chk(nc, 6 << i);
      chk(nh, 0);
    end
    pm(16'h0000);
    pm(16'hffff);
    seed = lfsr(seed);
    pm(seed[15:0]);
    wb(1'b1, `AEO_REG_CTRL, 4'h1, 32'h0);
    swp(16'd2048, 32);
    chk(nq, 0);
    chk(nc, 0);
    end_of_test();
  end
endmodule // aeo_top_tb
`default_nettype wire
